// >>> nvm_bus_pkg.sv
// Constants, types and timing counts for the parallel memory bus host.
// Assumes a 100 MHz system clock; all times become cycle counts here.
// Contract
// - Host waits the full 10 ms after a write unless it polls.
// - Successive page byte loads start between 0.2 us and 100 us apart.
// - Host allows at least 10 us before beginning the next write.
// - Drive may pulse low with select high between page loads harmlessly.
// - Drive low with select low between loads is a status poll.
// - Each page byte load follows a single store-strobe controlled write cycle.
// - Completion polling uses ordinary read cycles with read timing.
// - A started protection write sequence is issued without interruption.
package nvm_bus_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Read access and release figures, in nanoseconds.
  localparam int READ_CYCLE_NS    = 250;
  localparam int HIGHZ_NS         = 50;
  // Write strobe figures, in nanoseconds.
  localparam int STORE_PULSE_NS   = 100;
  localparam int STORE_HIGH_NS    = 100;
  localparam int DRIVE_SETUP_NS   = 10;
  localparam int ADDR_HOLD_NS     = 50;
  // Page and programming windows.
  localparam int LOAD_WINDOW_MIN_NS = 200;
  localparam int LOAD_WINDOW_MAX_US = 100;
  localparam int NEXT_WRITE_GAP_US  = 10;
  localparam int PROGRAM_TIME_MS    = 10;

  // Least times round up, longest times round down.
  localparam int READ_CYC     = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGHZ_CYC    = (HIGHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_CYC    = (STORE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_HI_CYC = (STORE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC    = (DRIVE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC     = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MIN_CYC = (LOAD_WINDOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_MAX_CYC = (LOAD_WINDOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int GAP_CYC      = (NEXT_WRITE_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYC  = (PROGRAM_TIME_MS * 1000000) / CLK_PERIOD_NS;

  localparam int CNT_W = 24;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 17;

  // Strobes toward the memory, all active low on the pins.
  typedef struct packed {
    logic select_n;
    logic drive_n;
    logic store_n;
  } strobe_s;

  localparam strobe_s STROBE_IDLE = 3'h7;

  // One host request.
  typedef struct packed {
    logic              write;
    logic              last;
    logic [ADDR_W-1:0] location;
    logic [DATA_W-1:0] data;
  } req_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_DRIVE, ST_RD_RELEASE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
    ST_PAGE_WAIT, ST_PROGRAM, ST_POLL, ST_GAP
  } host_state_e;

endpackage

// >>> nvm_cycle_timer.sv
// Down counter used to pace every phase of a bus cycle.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module nvm_cycle_timer #(
  parameter int W = 24
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_zero,
  output logic [W-1:0]      o_count
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // A load wins over the count so a new phase always starts cleanly.
  always_comb begin
    cnt_next = cnt_reg;
    if (i_load) begin
      cnt_next = i_value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_zero  = (cnt_reg == '0);
  assign o_count = cnt_reg;
endmodule
`default_nettype wire

// >>> nvm_bus_host.sv
// Host controller that drives a byte-wide electrically erasable memory
// through its select, drive and store strobes, location and byte lines.
// Assumes the byte lines are resolved outside from o_byte_oe; inputs from
// the pins pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
module nvm_bus_host #(
  parameter int PROGRAM_CYCLES = nvm_bus_pkg::PROGRAM_CYC,
  parameter int LOAD_MAX_CYCLES = nvm_bus_pkg::LOAD_MAX_CYC,
  parameter int GAP_CYCLES = nvm_bus_pkg::GAP_CYC,
  parameter bit USE_POLLING = 1'b1
) (
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_rst_n,
  input  wire logic                              i_req_valid,
  input  wire nvm_bus_pkg::req_s                 i_req,
  output logic                                   o_req_ready,
  output logic                                   o_rd_valid,
  output logic [nvm_bus_pkg::DATA_W-1:0]         o_rd_data,
  output logic                                   o_busy,
  output nvm_bus_pkg::strobe_s                   o_strobe,
  output logic [nvm_bus_pkg::ADDR_W-1:0]         o_location_lines,
  output logic [nvm_bus_pkg::DATA_W-1:0]         o_byte_lines,
  output logic                                   o_byte_oe,
  input  wire logic [nvm_bus_pkg::DATA_W-1:0]    i_byte_lines
);
  localparam int CW = nvm_bus_pkg::CNT_W;

  logic rst_s1_reg;
  logic rst_s2_reg;
  // Reset is released through two flops so all state leaves reset together.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  logic [nvm_bus_pkg::DATA_W-1:0] pin_s1_reg;
  logic [nvm_bus_pkg::DATA_W-1:0] pin_s2_reg;
  // Byte lines are asynchronous; only the second stage is read.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= i_byte_lines;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic          tmr_load;
  logic [CW-1:0] tmr_value;
  logic          tmr_zero;
  logic          win_load;
  logic [CW-1:0] win_value;
  logic          win_zero;
  logic [CW-1:0] win_count;

  nvm_cycle_timer #(.W(CW)) u_phase (
    .i_clk_sys(i_clk_sys), .i_rst_n(rst_n), .i_load(tmr_load),
    .i_value(tmr_value), .o_zero(tmr_zero), .o_count()
  );
  // Second timer tracks the byte load window and programming time.
  nvm_cycle_timer #(.W(CW)) u_window (
    .i_clk_sys(i_clk_sys), .i_rst_n(rst_n), .i_load(win_load),
    .i_value(win_value), .o_zero(win_zero), .o_count(win_count)
  );

  nvm_bus_pkg::host_state_e       state_reg, state_next;
  nvm_bus_pkg::strobe_s           strobe_reg, strobe_next;
  logic [nvm_bus_pkg::ADDR_W-1:0] loc_reg, loc_next;
  logic [nvm_bus_pkg::DATA_W-1:0] data_reg, data_next;
  logic                           oe_reg, oe_next;
  logic                           rdv_reg, rdv_next;
  logic [nvm_bus_pkg::DATA_W-1:0] rdd_reg, rdd_next;
  logic                           page_reg, page_next;
  logic                           last_reg, last_next;
  logic                           ready_reg, ready_next;
  logic                           poll_reg, poll_next;
  logic                           prev_bit_reg, prev_bit_next;
  logic                           pend_reg, pend_next;
  logic                           busy_reg, busy_next;

  // Bus sequencer: strobes change on an accepted request or when a timer runs out.
  always_comb begin
    state_next = state_reg;
    strobe_next = strobe_reg;
    loc_next = loc_reg;
    data_next = data_reg;
    oe_next = oe_reg;
    rdv_next = 1'b0;
    rdd_next = rdd_reg;
    page_next = page_reg;
    last_next = last_reg;
    poll_next = poll_reg;
    prev_bit_next = prev_bit_reg;
    pend_next = pend_reg;
    ready_next = 1'b0;
    tmr_load = 1'b0;
    tmr_value = '0;
    win_load = 1'b0;
    win_value = '0;
    case (state_reg)
      nvm_bus_pkg::ST_IDLE: begin
        ready_next = 1'b1;
        if (i_req_valid && ready_reg) begin
          ready_next = 1'b0;
          loc_next = i_req.location;
          data_next = i_req.data;
          last_next = i_req.last;
          tmr_load = 1'b1;
          if (i_req.write) begin
            state_next = nvm_bus_pkg::ST_WR_SETUP;
            strobe_next = '{select_n: 1'b0, drive_n: 1'b1, store_n: 1'b1};
            oe_next = 1'b1;
            tmr_value = CW'(nvm_bus_pkg::SETUP_CYC);
          end else begin
            state_next = nvm_bus_pkg::ST_RD_DRIVE;
            strobe_next = '{select_n: 1'b0, drive_n: 1'b0, store_n: 1'b1};
            oe_next = 1'b0;
            tmr_value = CW'(nvm_bus_pkg::READ_CYC);
          end
        end
      end
      nvm_bus_pkg::ST_RD_DRIVE, nvm_bus_pkg::ST_POLL: begin
        // Polls run full read cycles before sampling.
        if (tmr_zero) begin
          strobe_next = nvm_bus_pkg::STROBE_IDLE;
          tmr_load = 1'b1;
          tmr_value = CW'(nvm_bus_pkg::HIGHZ_CYC);
          if (state_reg == nvm_bus_pkg::ST_RD_DRIVE) begin
            // Only real reads update the read data; polls leave it alone.
            rdd_next = pin_s2_reg;
            rdv_next = 1'b1;
            state_next = nvm_bus_pkg::ST_RD_RELEASE;
          end else begin
            // Toggle bit stops changing when programming ends.
            // The first poll of a program only seeds the compare, so a stale bit cannot end it early.
            poll_next = 1'b1;
            prev_bit_next = pin_s2_reg[6];
            state_next = nvm_bus_pkg::ST_PROGRAM;
            if (poll_reg && (pin_s2_reg[6] == prev_bit_reg)) begin
              state_next = nvm_bus_pkg::ST_GAP;
              win_load = 1'b1;
              win_value = CW'(GAP_CYCLES);
            end
          end
        end
      end
      nvm_bus_pkg::ST_RD_RELEASE: begin
        // Wait out the release time before the next cycle.
        if (tmr_zero) begin
          state_next = nvm_bus_pkg::ST_IDLE;
        end
      end
      nvm_bus_pkg::ST_WR_SETUP: begin
        if (tmr_zero) begin
          strobe_next.store_n = 1'b0;
          tmr_load = 1'b1;
          tmr_value = CW'(nvm_bus_pkg::STORE_CYC);
          state_next = nvm_bus_pkg::ST_WR_PULSE;
        end
      end
      nvm_bus_pkg::ST_WR_PULSE: begin
        if (tmr_zero) begin
          strobe_next = nvm_bus_pkg::STROBE_IDLE;
          tmr_load = 1'b1;
          tmr_value = CW'(nvm_bus_pkg::STORE_HI_CYC);
          win_load = 1'b1;
          win_value = CW'(LOAD_MAX_CYCLES - nvm_bus_pkg::STORE_HI_CYC - 4);
          state_next = nvm_bus_pkg::ST_WR_HOLD;
        end
      end
      nvm_bus_pkg::ST_WR_HOLD: begin
        // Select high releases the memory between loads.
        if (tmr_zero) begin
          oe_next = 1'b0;
          if (last_reg) begin
            state_next = nvm_bus_pkg::ST_PROGRAM;
            poll_next = 1'b0;
            win_load = 1'b1;
            win_value = CW'(PROGRAM_CYCLES);
          end else begin
            page_next = 1'b1;
            state_next = nvm_bus_pkg::ST_PAGE_WAIT;
          end
        end
      end
      nvm_bus_pkg::ST_PAGE_WAIT: begin
        // Next load must come inside the window, else close the page.
        ready_next = 1'b1;
        // Loads of a sequence go out with no other cycle between them.
        if (i_req_valid && ready_reg && i_req.write) begin
          ready_next = 1'b0;
          loc_next = i_req.location;
          data_next = i_req.data;
          last_next = i_req.last;
          oe_next = 1'b1;
          strobe_next = '{select_n: 1'b0, drive_n: 1'b1, store_n: 1'b1};
          tmr_load = 1'b1;
          tmr_value = CW'(nvm_bus_pkg::SETUP_CYC);
          state_next = nvm_bus_pkg::ST_WR_SETUP;
        end else if (i_req_valid && ready_reg) begin
          // A read here would act as a poll, so it closes the page and waits for the gap.
          ready_next = 1'b0;
          loc_next = i_req.location;
          pend_next = 1'b1;
          page_next = 1'b0;
          poll_next = 1'b0;
          state_next = nvm_bus_pkg::ST_PROGRAM;
          win_load = 1'b1;
          win_value = CW'(PROGRAM_CYCLES);
        end else if (win_zero) begin
          ready_next = 1'b0;
          page_next = 1'b0;
          poll_next = 1'b0;
          state_next = nvm_bus_pkg::ST_PROGRAM;
          win_load = 1'b1;
          win_value = CW'(PROGRAM_CYCLES);
        end
      end
      nvm_bus_pkg::ST_PROGRAM: begin
        // Full wait unless a poll shows completion.
        // No new loads are issued while programming.
        page_next = 1'b0;
        if (win_zero) begin
          state_next = nvm_bus_pkg::ST_GAP;
          win_load = 1'b1;
          win_value = CW'(GAP_CYCLES);
        end else if (USE_POLLING && tmr_zero) begin
          strobe_next = '{select_n: 1'b0, drive_n: 1'b0, store_n: 1'b1};
          tmr_load = 1'b1;
          tmr_value = CW'(nvm_bus_pkg::READ_CYC);
          state_next = nvm_bus_pkg::ST_POLL;
        end
      end
      nvm_bus_pkg::ST_GAP: begin
        if (win_zero) begin
          state_next = nvm_bus_pkg::ST_IDLE;
          // A read held back by a closed page runs once the gap is over.
          if (pend_reg) begin
            pend_next = 1'b0;
            strobe_next = '{select_n: 1'b0, drive_n: 1'b0, store_n: 1'b1};
            tmr_load = 1'b1;
            tmr_value = CW'(nvm_bus_pkg::READ_CYC);
            state_next = nvm_bus_pkg::ST_RD_DRIVE;
          end
        end
      end
      default: begin
        state_next = nvm_bus_pkg::ST_IDLE;
        strobe_next = nvm_bus_pkg::STROBE_IDLE;
        oe_next = 1'b0;
      end
    endcase
    busy_next = (state_next != nvm_bus_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= nvm_bus_pkg::ST_IDLE;
      strobe_reg <= nvm_bus_pkg::STROBE_IDLE;
      loc_reg <= 17'h00000;
      data_reg <= 8'h00;
      oe_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rdd_reg <= 8'h00;
      page_reg <= 1'b0;
      last_reg <= 1'b0;
      ready_reg <= 1'b0;
      poll_reg <= 1'b0;
      prev_bit_reg <= 1'b0;
      pend_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      strobe_reg <= strobe_next;
      loc_reg <= loc_next;
      data_reg <= data_next;
      oe_reg <= oe_next;
      rdv_reg <= rdv_next;
      rdd_reg <= rdd_next;
      page_reg <= page_next;
      last_reg <= last_next;
      ready_reg <= ready_next;
      poll_reg <= poll_next;
      prev_bit_reg <= prev_bit_next;
      pend_reg <= pend_next;
      busy_reg <= busy_next;
    end
  end

  assign o_req_ready = ready_reg;
  assign o_rd_valid = rdv_reg;
  assign o_rd_data = rdd_reg;
  assign o_busy = busy_reg;
  assign o_strobe = strobe_reg;
  assign o_location_lines = loc_reg;
  assign o_byte_lines = data_reg;
  assign o_byte_oe = oe_reg;

  // Host never drives the byte lines while the memory may drive them.
  a_no_contention: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !(o_byte_oe && !o_strobe.drive_n)) else $error("Byte lines driven during read.");
  // A store pulse only occurs with select low and drive high.
  a_store_mode: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    !o_strobe.store_n |-> (!o_strobe.select_n && o_strobe.drive_n && o_byte_oe))
    else $error("Store pulse in wrong mode.");
  // Store pulse holds low for at least eight cycles once it falls.
  a_store_width: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $fell(o_strobe.store_n) |-> !o_strobe.store_n [*8]) else $error("Store pulse too short.");
  // Programming phase never issues a store.
  a_no_load_prog: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    state_reg == nvm_bus_pkg::ST_PROGRAM |-> o_strobe.store_n) else $error("Load during programming.");
  // Reads hold drive low for at least eight cycles once it falls.
  a_read_len: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $fell(o_strobe.drive_n) |-> !o_strobe.drive_n [*8]) else $error("Read cycle too short.");
  // After programming, a gap precedes a return to idle.
  a_gap_follows: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    state_reg == nvm_bus_pkg::ST_GAP && $past(state_reg) != nvm_bus_pkg::ST_GAP
    |-> state_reg != nvm_bus_pkg::ST_IDLE [*8]) else $error("Write gap too short.");
  // The release wait follows every read strobe rise that ends a real read.
  a_release: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    $rose(o_strobe.drive_n) && state_reg == nvm_bus_pkg::ST_RD_RELEASE
    |-> o_strobe.drive_n [*5]) else $error("Release time cut short.");
  // Page wait leaves strobes idle, so no stray drive pulse reaches the memory.
  a_page_idle: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
    state_reg == nvm_bus_pkg::ST_PAGE_WAIT |-> o_strobe == nvm_bus_pkg::STROBE_IDLE)
    else $error("Strobes active between page loads.");
endmodule
`default_nettype wire

// >>> nvm_mem_model.sv
// Behavioural model of the byte-wide nonvolatile memory on the far side of the host.
// Assumes the bench resolves the byte lines and feeds the resolved value back in.
`timescale 1ns/1ps
`default_nettype none
module nvm_mem_model #(
  parameter int PROGRAM_NS  = 1500,
  parameter int WINDOW_NS   = 900,
  parameter int LOAD_MIN_NS = 200,
  parameter int GAP_NS      = 200,
  parameter int PULSE_NS    = 100
) (
  input  wire nvm_bus_pkg::strobe_s           i_strobe,
  input  wire logic [nvm_bus_pkg::ADDR_W-1:0] i_location,
  input  wire logic [7:0]                     i_bus,
  output logic [7:0]                          o_data,
  output logic                                o_oe,
  output logic                                o_busy,
  output logic [7:0]                          o_faults
);
  logic [7:0]                  mem [int];
  logic [nvm_bus_pkg::ADDR_W-1:0] load_loc;
  logic                        armed  = 1'b0;
  logic                        toggle = 1'b0;
  time                         t_fall = 0;
  time                         t_last = 0;
  time                         t_done = 0;

  initial begin
    o_busy = 1'b0;
    o_faults = 8'h00;
    o_data = 8'hFF;
  end

  // Read output gating; drive low with select high does nothing.
  // Release is instant when select or drive rises, so it is never late.
  assign o_oe = !i_strobe.select_n && !i_strobe.drive_n && i_strobe.store_n;

  // Poll answers.
  // While programming, bit 6 flips on each read so the host can spot the end.
  // The location launched on the same edge as the strobes is settled after one step.
  always @(posedge o_oe) begin
    #1;
    if (o_busy) begin
      toggle = ~toggle;
      o_data = {1'b0, toggle, 6'h00};
    end else begin
      o_data = mem.exists(int'(i_location)) ? mem[int'(i_location)] : 8'hFF;
    end
  end

  always @(negedge i_strobe.store_n) begin
    armed = !i_strobe.select_n && i_strobe.drive_n;
    load_loc = i_location;
    t_fall = $time;
    if (!i_strobe.select_n && !i_strobe.drive_n) o_faults = o_faults + 8'h01;
  end

  // Load commit and spacing.
  // A load after the page has closed is ignored and counted as a host fault.
  always @(posedge i_strobe.store_n) begin
    if (armed) begin
      if ($time - t_fall < PULSE_NS) o_faults = o_faults + 8'h01;
      if (o_busy && $time - t_last > WINDOW_NS) begin
        o_faults = o_faults + 8'h01;
      end else begin
        if (o_busy && $time - t_last < LOAD_MIN_NS) o_faults = o_faults + 8'h01;
        if (!o_busy && t_done != 0 && $time - t_done < GAP_NS) o_faults = o_faults + 8'h01;
        mem[int'(load_loc)] = i_bus;
        t_last = $time;
        o_busy = 1'b1;
      end
    end
    armed = 1'b0;
  end

  // Self-timed programming end.
  // Stepped off the host clock edges so the bench never races it.
  initial begin
    #2;
    forever begin
      #10;
      if (o_busy && $time - t_last >= PROGRAM_NS) begin
        o_busy = 1'b0;
        t_done = $time;
      end
    end
  end
endmodule
`default_nettype wire

// >>> eeprom_async_bus_write_control_tb.sv
// Self-checking bench for the memory bus host against a behavioural memory.
// Assumes shortened programming, page and gap counts set on the instance.
`timescale 1ns/1ps
`default_nettype none
module eeprom_async_bus_write_control_tb;
  localparam int LIMIT = 20000;
  logic                           i_clk_sys   = 1'b0;
  logic                           i_rst_n     = 1'b0;
  logic                           i_req_valid = 1'b0;
  nvm_bus_pkg::req_s              i_req       = '0;
  logic                           o_req_ready;
  logic                           o_rd_valid;
  logic                           o_busy;
  logic                           o_byte_oe;
  logic                           mem_oe;
  logic                           mem_busy;
  logic [7:0]                     o_rd_data;
  logic [7:0]                     o_byte_lines;
  logic [7:0]                     mem_data;
  logic [7:0]                     mem_faults;
  logic [7:0]                     bus;
  logic [7:0]                     bus_last    = 8'h00;
  logic [7:0]                     clashes     = 8'h00;
  nvm_bus_pkg::strobe_s           o_strobe;
  logic [nvm_bus_pkg::ADDR_W-1:0] o_location_lines;
  int                             errors      = 0;
  int                             n_tests     = 0;
  int                             cycles      = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  nvm_bus_host #(.PROGRAM_CYCLES(200), .LOAD_MAX_CYCLES(60), .GAP_CYCLES(20), .USE_POLLING(1'b1)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_busy(o_busy),
    .o_strobe(o_strobe), .o_location_lines(o_location_lines), .o_byte_lines(o_byte_lines),
    .o_byte_oe(o_byte_oe), .i_byte_lines(bus));

  nvm_mem_model mem (.i_strobe(o_strobe), .i_location(o_location_lines), .i_bus(bus),
    .o_data(mem_data), .o_oe(mem_oe), .o_busy(mem_busy), .o_faults(mem_faults));

  // Resolved byte lines; floating lines show the inverse of the last driven value.
  assign bus = o_byte_oe ? o_byte_lines : (mem_oe ? mem_data : ~bus_last);

  // Watch for both ends driving at once, and cut a hang short.
  always @(posedge i_clk_sys) begin
    if (o_byte_oe || mem_oe) bus_last <= bus;
    if (o_byte_oe === 1'b1 && mem_oe) clashes <= clashes + 8'h01;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request from one edge until the edge where ready is seen high.
  task automatic send(input logic w, input logic last, input logic [16:0] loc, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_req_valid <= 1'b1;
    i_req <= '{write: w, last: last, location: loc, data: d};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_req_ready !== 1'b1 && n < 5000);
    i_req_valid <= 1'b0;
    if (n >= 5000) chk1("request taken", 1'b1, 1'b0);
  endtask

  // A read met while a page is open is taken at once but runs after programming.
  task automatic read_check(input logic [16:0] loc, input logic [7:0] exp, input logic busy);
    int n;
    send(1'b0, 1'b0, loc, 8'h00);
    chk1("memory busy when read taken", busy, mem_busy);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_rd_valid !== 1'b1 && n < 1000);
    chk8("read data", exp, o_rd_data);
    @(posedge i_clk_sys);
    chk1("read valid pulse ended", 1'b0, o_rd_valid);
  endtask

  // Ready must not come back before the memory has finished programming.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge i_clk_sys);
    chk1("busy while writing", 1'b1, o_busy);
    while (o_req_ready !== 1'b1 && n < 5000) begin
      @(posedge i_clk_sys);
      n++;
    end
    chk1("memory done before ready", 1'b0, mem_busy);
    chk1("busy after programming", 1'b0, o_busy);
  endtask

  task automatic t_reset();
    repeat (10) @(posedge i_clk_sys);
    chk8("strobes in reset", {5'h00, nvm_bus_pkg::STROBE_IDLE}, {5'h00, o_strobe});
    chk1("byte drive in reset", 1'b0, o_byte_oe);
    chk1("ready in reset", 1'b0, o_req_ready);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask

  task automatic t_single_write();
    send(1'b1, 1'b1, 17'h00012, 8'h5A);
    wait_idle();
    read_check(17'h00012, 8'h5A, 1'b0);
  endtask

  // Three loads back to back, closed by the last flag.
  task automatic t_page_write();
    send(1'b1, 1'b0, 17'h00100, 8'hA5);
    send(1'b1, 1'b0, 17'h00101, 8'h3C);
    send(1'b1, 1'b1, 17'h00102, 8'hC3);
    wait_idle();
    read_check(17'h00100, 8'hA5, 1'b0);
    read_check(17'h00101, 8'h3C, 1'b0);
    read_check(17'h00102, 8'hC3, 1'b0);
  endtask

  // Page left open times out and programs; a read met in an open page closes it and waits.
  task automatic t_page_timeout();
    send(1'b1, 1'b0, 17'h1FFFF, 8'h81);
    repeat (80) @(posedge i_clk_sys);
    chk1("page closed by timeout", 1'b0, o_req_ready);
    read_check(17'h1FFFF, 8'h81, 1'b0);
    send(1'b1, 1'b0, 17'h00000, 8'h7E);
    read_check(17'h00000, 8'h7E, 1'b1);
  endtask

  task automatic t_erased_reads();
    read_check(17'h0FFFF, 8'hFF, 1'b0);
    read_check(17'h10000, 8'hFF, 1'b0);
    send(1'b1, 1'b1, 17'h10000, 8'h00);
    wait_idle();
    read_check(17'h10000, 8'h00, 1'b0);
  endtask

  initial begin
    t_reset();
    t_single_write();
    t_page_write();
    t_page_timeout();
    t_erased_reads();
    chk8("memory model faults", 8'h00, mem_faults);
    chk8("byte line clashes", 8'h00, clashes);
    tally_and_finish();
  end
endmodule
`default_nettype wire
